// File: pms_pkg.sv
// power mode selector package: register map, field positions, mode codes.
// assumes a 32-bit apb register bus and the 125 MHz system clock.
package pms_pkg;

	localparam int ADDR_W = 12;
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] STAT_OFS = 12'h004;

	// control register fields
	localparam int C_LPR = 0;
	localparam int C_PARTIAL_POWERDOWN_REQUEST = 1;
	localparam int C_WFR = 2;
	localparam int C_VDE = 3;
	localparam int C_VDSE = 4;
	localparam int C_STOP_INSTRUCTION_ENABLE = 5;
	localparam int C_IRSTEN = 6;
	localparam int C_ERSTEN = 7;
	localparam int C_INTERNAL_REF_CLOCK_ENABLE = 8;
	localparam int C_EXTERNAL_REF_CLOCK_ENABLE = 9;
	localparam int C_ACK = 16;
	localparam int CTRL_W = 10;
	localparam logic [9:0] CTRL_RST = 10'h000;

	// status register fields
	localparam int S_MODE = 0;
	localparam int S_LOW_POWER_RUN_STATUS = 3;
	localparam int S_PDWF = 4;
	localparam int S_DBG = 5;

	typedef enum logic [2:0] {
		M_RUN = 3'b000,
		M_LOW_POWER_RUN = 3'b001,
		M_WAIT = 3'b010,
		M_LOW_POWER_WAIT = 3'b011,
		M_RSTOP = 3'b100,
		M_PDSTOP = 3'b101
	} pms_mode_t;

	typedef enum logic [1:0] {
		REG_FULL = 2'b00,
		REG_STANDBY = 2'b01,
		REG_PARTIAL = 2'b10
	} pms_reg_t;

endpackage

// File: pms_power_mode_selector.sv
// power mode selector: run, low power run, wait, low power wait,
// retention stop and powerdown stop, with clock and regulator controls.
// assumes cpu wait/stop/interrupt strobes are one-cycle pulses on CLOCK_I
// and that clock generator and regulator follow the level outputs.
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module pms_power_mode_selector
	import pms_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic PSEL_I,
	input wire logic PENABLE_I,
	input wire logic PWRITE_I,
	input wire logic [ADDR_W-1:0] PADDR_I,
	input wire logic [31:0] PWDATA_I,
	output logic [31:0] PRDATA_O,
	output logic PREADY_O,
	output logic PSLVERR_O,
	input wire logic DBG_WR_I,
	input wire logic DBG_ENABLE_I,
	input wire logic WAIT_EXEC_I,
	input wire logic STOP_EXEC_I,
	input wire logic IRQ_I,
	input wire logic STOP_RST_I,
	input wire logic WAKE_PIN_I,
	input wire logic TOD_IRQ_I,
	output logic [2:0] MODE_O,
	output logic CPU_CLK_EN_O,
	output logic PERIPH_CLK_EN_O,
	output logic PERIPH_SLOW_O,
	output logic DEBUG_CLK_EN_O,
	output logic CLKGEN_LOW_POWER_O,
	output logic CLKGEN_STOP_O,
	output logic EXT_REF_CLK_EN_O,
	output logic INT_REF_CLK_EN_O,
	output logic OSC_OUT_EN_O,
	output logic [1:0] REGULATOR_O,
	output logic POWERDOWN_O,
	output logic IRQ_SERVICE_O,
	output logic ILLEGAL_OP_RST_O,
	output logic POR_RESTART_O
);

	////////////////////////////////////////////////////////////////////////
	// state

	pms_mode_t mode_q, mode_d;
	logic [CTRL_W-1:0] ctrl_q, ctrl_d;
	logic dbg_q;
	logic low_power_run_status_q, low_power_run_status_d;
	logic pdwf_q;
	logic [31:0] prdata_q;
	logic pready_q, pslverr_q;
	logic service_q, illegal_q, por_q;
	logic service_d, illegal_d, por_d;

	// debug or detector in stop holds the regulator full in retention stop
	function automatic pms_reg_t reg_for(input pms_mode_t m,
		input logic keep_on);
		unique case (m)
			M_RUN, M_WAIT: reg_for = REG_FULL;
			M_LOW_POWER_RUN, M_LOW_POWER_WAIT: reg_for = REG_STANDBY;
			M_RSTOP: reg_for = keep_on ? REG_FULL : REG_STANDBY;
			M_PDSTOP: reg_for = REG_PARTIAL;
			default: reg_for = REG_FULL;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire setup = PSEL_I & ~PENABLE_I;
	// a write lands only on the edge that samples ready high
	wire access = PSEL_I & PENABLE_I & pready_q;
	wire hit_ctrl = PADDR_I == CTRL_OFS;
	wire hit_stat = PADDR_I == STAT_OFS;
	wire wr_ctrl = access & PWRITE_I & hit_ctrl;
	wire [31:0] rd_ctrl = {{(32-CTRL_W){1'b0}}, ctrl_q};
	// status is read only: writes to it are dropped without an error
	wire [31:0] rd_stat = {26'h0, dbg_q, pdwf_q, low_power_run_status_q, mode_q};
	wire [31:0] rd_mux = hit_ctrl ? rd_ctrl : (hit_stat ? rd_stat : 32'h0);

	////////////////////////////////////////////////////////////////////////
	// mode conditions

	wire low_power_run_request = ctrl_q[C_LPR];
	wire partial_powerdown_request = ctrl_q[C_PARTIAL_POWERDOWN_REQUEST];
	wire wfr = ctrl_q[C_WFR];
	wire vd_stop = ctrl_q[C_VDE] & ctrl_q[C_VDSE];
	// detector in stop blocks low power run and keeps the regulator on
	wire lp_ok = ~dbg_q & ~vd_stop & low_power_run_request & ~partial_powerdown_request;
	wire pd_ok = ~dbg_q & ~vd_stop & ~low_power_run_request & partial_powerdown_request;
	wire wake_any = STOP_RST_I | IRQ_I;

	// exclusive request bits: powerdown wins a simultaneous first write
	wire w_partial_powerdown_request = PWDATA_I[C_PARTIAL_POWERDOWN_REQUEST] & ~low_power_run_request;
	wire w_lpr = PWDATA_I[C_LPR] & ~partial_powerdown_request & ~w_partial_powerdown_request;

	////////////////////////////////////////////////////////////////////////
	// next mode

	always_comb begin
		mode_d = mode_q;
		service_d = 1'b0;
		illegal_d = 1'b0;
		por_d = 1'b0;
		ctrl_d = ctrl_q;
		if (wr_ctrl) begin
			ctrl_d = PWDATA_I[CTRL_W-1:0];
			ctrl_d[C_PARTIAL_POWERDOWN_REQUEST] = w_partial_powerdown_request;
			ctrl_d[C_LPR] = w_lpr;
		end
		unique case (mode_q)
			M_RUN, M_LOW_POWER_RUN: begin
				if (STOP_EXEC_I && !ctrl_q[C_STOP_INSTRUCTION_ENABLE]) begin
					illegal_d = 1'b1;
					mode_d = M_RUN;
				end else if (STOP_EXEC_I) begin
					// low power run always lands in retention stop
					if (mode_q == M_RUN && pd_ok)
						mode_d = M_PDSTOP;
					else
						mode_d = M_RSTOP;
				end else if (WAIT_EXEC_I) begin
					mode_d = (mode_q == M_LOW_POWER_RUN) ? M_LOW_POWER_WAIT : M_WAIT;
				end else if (mode_q == M_LOW_POWER_RUN && IRQ_I && wfr) begin
					mode_d = M_RUN;
					ctrl_d[C_LPR] = 1'b0;
				end else begin
					mode_d = lp_ok ? M_LOW_POWER_RUN : M_RUN;
				end
			end
			M_WAIT: begin
				if (wake_any) begin
					mode_d = M_RUN;
					service_d = IRQ_I & ~STOP_RST_I;
				end
			end
			M_LOW_POWER_WAIT, M_RSTOP: begin
				if (STOP_RST_I) begin
					mode_d = M_RUN;
					// drop the request, or run slides back to low power
					ctrl_d[C_LPR] = 1'b0;
				end else if (IRQ_I) begin
					service_d = 1'b1;
					if (low_power_run_status_q && !wfr) begin
						mode_d = M_LOW_POWER_RUN;
					end else begin
						mode_d = M_RUN;
						ctrl_d[C_LPR] = 1'b0;
					end
				end
			end
			M_PDSTOP: begin
				if (WAKE_PIN_I || TOD_IRQ_I) begin
					// restart as power-on; power control bits survive
					mode_d = M_RUN;
					por_d = 1'b1;
					ctrl_d[C_STOP_INSTRUCTION_ENABLE] = 1'b0;
					ctrl_d[C_IRSTEN] = 1'b0;
					ctrl_d[C_ERSTEN] = 1'b0;
					ctrl_d[C_INTERNAL_REF_CLOCK_ENABLE] = 1'b0;
					ctrl_d[C_EXTERNAL_REF_CLOCK_ENABLE] = 1'b0;
				end
			end
			default: mode_d = M_RUN;
		endcase
	end

	// status tracks low power run through wait and retention stop
	assign low_power_run_status_d = (mode_d == M_LOW_POWER_RUN) || (mode_d == M_LOW_POWER_WAIT) ||
		(mode_d == M_RSTOP && (low_power_run_status_q || mode_q == M_LOW_POWER_RUN));

	////////////////////////////////////////////////////////////////////////
	// output decode

	wire in_stop = (mode_d == M_RSTOP) || (mode_d == M_PDSTOP);
	wire in_lp = (mode_d == M_LOW_POWER_RUN) || (mode_d == M_LOW_POWER_WAIT);
	wire cpu_on = (mode_d == M_RUN) || (mode_d == M_LOW_POWER_RUN);
	// references run on in stop only where their stop enable is set
	wire ext_on = ctrl_d[C_EXTERNAL_REF_CLOCK_ENABLE] & (~in_stop | ctrl_d[C_ERSTEN]);
	wire int_on = ctrl_d[C_INTERNAL_REF_CLOCK_ENABLE] & (~in_stop | ctrl_d[C_IRSTEN]);
	// powerdown keeps only the oscillator, for the counter and display
	wire pd_next = mode_d == M_PDSTOP;
	wire dbg_d = DBG_WR_I ? DBG_ENABLE_I : dbg_q;
	wire keep_d = dbg_d | (ctrl_d[C_VDE] & ctrl_d[C_VDSE]);

	////////////////////////////////////////////////////////////////////////
	// registers

	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			mode_q <= M_RUN;
			ctrl_q <= CTRL_RST;
			low_power_run_status_q <= 1'b0;
			service_q <= 1'b0;
			illegal_q <= 1'b0;
			por_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			ctrl_q <= ctrl_d;
			low_power_run_status_q <= low_power_run_status_d;
			service_q <= service_d;
			illegal_q <= illegal_d;
			por_q <= por_d;
		end
	end

	// only the debug port reaches this bit
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I)
			dbg_q <= 1'b0;
		else
			dbg_q <= dbg_d;
	end

	// wake sets and wins over a same-cycle acknowledge
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I)
			pdwf_q <= 1'b0;
		else if (por_d)
			pdwf_q <= 1'b1;
		else if (wr_ctrl && PWDATA_I[C_ACK])
			pdwf_q <= 1'b0;
	end

	// zero wait states: ready answers the setup cycle
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0;
		end else begin
			pready_q <= setup;
			pslverr_q <= setup & ~hit_ctrl & ~hit_stat;
			prdata_q <= (setup & ~PWRITE_I) ? rd_mux : 32'h0;
		end
	end

	// clock and regulator controls, registered from the next mode
	always_ff @(posedge CLOCK_I) begin
		if (SYS_RST_I) begin
			CPU_CLK_EN_O <= 1'b1;
			PERIPH_CLK_EN_O <= 1'b1;
			PERIPH_SLOW_O <= 1'b0;
			CLKGEN_LOW_POWER_O <= 1'b0;
			CLKGEN_STOP_O <= 1'b0;
			EXT_REF_CLK_EN_O <= 1'b0;
			INT_REF_CLK_EN_O <= 1'b0;
			OSC_OUT_EN_O <= 1'b0;
			REGULATOR_O <= REG_FULL;
			POWERDOWN_O <= 1'b0;
			DEBUG_CLK_EN_O <= 1'b0;
		end else begin
			CPU_CLK_EN_O <= cpu_on;
			PERIPH_CLK_EN_O <= ~in_stop;
			PERIPH_SLOW_O <= in_lp;
			CLKGEN_LOW_POWER_O <= in_lp;
			CLKGEN_STOP_O <= in_stop;
			EXT_REF_CLK_EN_O <= ext_on & ~pd_next;
			INT_REF_CLK_EN_O <= int_on & ~pd_next;
			OSC_OUT_EN_O <= ext_on;
			REGULATOR_O <= reg_for(mode_d, keep_d);
			POWERDOWN_O <= pd_next;
			DEBUG_CLK_EN_O <= dbg_d;
		end
	end

	assign MODE_O = mode_q;
	assign PRDATA_O = prdata_q;
	assign PREADY_O = pready_q;
	assign PSLVERR_O = pslverr_q;
	assign IRQ_SERVICE_O = service_q;
	assign ILLEGAL_OP_RST_O = illegal_q;
	assign POR_RESTART_O = por_q;

endmodule

`default_nettype wire

// File: pms_props.sv
// checker: mode to clock, regulator and wake relations.
// assumes it is bound to the selector top and sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module pms_props
	import pms_pkg::*;
(
	input wire logic CLOCK_I,
	input wire logic SYS_RST_I,
	input wire logic DBG_WR_I,
	input wire logic DBG_ENABLE_I,
	input wire logic STOP_EXEC_I,
	input wire logic IRQ_I,
	input wire logic STOP_RST_I,
	input wire logic [2:0] MODE_O,
	input wire logic CPU_CLK_EN_O,
	input wire logic PERIPH_CLK_EN_O,
	input wire logic DEBUG_CLK_EN_O,
	input wire logic CLKGEN_LOW_POWER_O,
	input wire logic [1:0] REGULATOR_O,
	input wire logic POWERDOWN_O,
	input wire logic IRQ_SERVICE_O,
	input wire logic ILLEGAL_OP_RST_O
);
	default clocking cb @(posedge CLOCK_I);
	endclocking
	default disable iff (SYS_RST_I);
	sequence s_lp_stop;
		MODE_O == M_LOW_POWER_RUN && STOP_EXEC_I;
	endsequence
	sequence s_ret_irq;
		MODE_O == M_RSTOP && IRQ_I && !STOP_RST_I;
	endsequence
	a_lp_stop_ret: assert property (s_lp_stop |=>
		MODE_O == M_RSTOP || ILLEGAL_OP_RST_O) else $error("lp stop");
	a_no_pd_lp: assert property (MODE_O == M_LOW_POWER_RUN |=>
		MODE_O != M_PDSTOP) else $error("pd from lp run");
	a_ret_irq_wake: assert property (s_ret_irq |=>
		MODE_O inside {M_LOW_POWER_RUN, M_RUN} && IRQ_SERVICE_O) else $error("wake");
	a_ret_rst_run: assert property (MODE_O == M_RSTOP && STOP_RST_I |=>
		MODE_O == M_RUN) else $error("reset exit");
	a_lp_run_out: assert property (MODE_O == M_LOW_POWER_RUN |->
		CLKGEN_LOW_POWER_O && REGULATOR_O == REG_STANDBY) else $error("lp out");
	a_lp_wait_out: assert property (MODE_O == M_LOW_POWER_WAIT |->
		!CPU_CLK_EN_O && CLKGEN_LOW_POWER_O && REGULATOR_O == REG_STANDBY)
		else $error("lp wait out");
	a_wait_out: assert property (MODE_O == M_WAIT |->
		!CPU_CLK_EN_O && PERIPH_CLK_EN_O && REGULATOR_O == REG_FULL)
		else $error("wait out");
	a_ret_dbg_reg: assert property (MODE_O == M_RSTOP && DEBUG_CLK_EN_O |->
		REGULATOR_O == REG_FULL) else $error("stop debug");
	a_pd_out: assert property (MODE_O == M_PDSTOP |->
		REGULATOR_O == REG_PARTIAL && POWERDOWN_O && !CPU_CLK_EN_O)
		else $error("pd out");
	a_dbg_clk: assert property (DBG_WR_I |=>
		DEBUG_CLK_EN_O == $past(DBG_ENABLE_I)) else $error("debug clock");
endmodule
`default_nettype wire

// File: pms_cpu_model.sv
// cpu core stand-in: wait/stop/interrupt/wake pulses, debug port writes.
// assumes tasks are called from the bench between rising edges.
`timescale 1ns/100ps
`default_nettype none
module pms_cpu_model (
	input wire logic clk_i,
	output logic [5:0] ev_o,
	output logic dbg_wr_o,
	output logic dbg_en_o
);
	initial begin
		ev_o = '0;
		dbg_wr_o = 1'b0;
		dbg_en_o = 1'b0;
	end
	// one-cycle strobes: tod, wake, stop reset, irq, stop, wait
	task pulse(input logic [5:0] m);
		@(posedge clk_i);
		ev_o <= m;
		@(posedge clk_i);
		ev_o <= '0;
	endtask
	// debug enable only ever moves through this port
	task dbg(input logic v);
		@(posedge clk_i);
		dbg_wr_o <= 1'b1;
		dbg_en_o <= v;
		@(posedge clk_i);
		dbg_wr_o <= 1'b0;
		dbg_en_o <= ~v;
	endtask
endmodule
`default_nettype wire

// File: tb.sv
// bench for the power mode selector, apb master and cpu stand-in.
// assumes the zero-wait apb slave and one-edge output latency.
`timescale 1ns/100ps
`default_nettype none
module tb
	import pms_pkg::*;
;
	logic CLOCK_I = 1'b0;
	logic SYS_RST_I = 1'b1;
	logic PSEL_I = 1'b0;
	logic PENABLE_I = 1'b0;
	logic PWRITE_I = 1'b0;
	logic [11:0] PADDR_I = '0;
	logic [31:0] PWDATA_I = '0;
	logic [31:0] PRDATA_O, rdat;
	logic [2:0] MODE_O;
	logic [1:0] REGULATOR_O;
	logic [5:0] ev;
	logic PREADY_O, PSLVERR_O, DBG_WR_I, DBG_ENABLE_I, serr;
	logic CPU_CLK_EN_O, PERIPH_CLK_EN_O, PERIPH_SLOW_O, DEBUG_CLK_EN_O;
	logic CLKGEN_LOW_POWER_O, CLKGEN_STOP_O, EXT_REF_CLK_EN_O;
	logic INT_REF_CLK_EN_O, OSC_OUT_EN_O, POWERDOWN_O, IRQ_SERVICE_O;
	logic ILLEGAL_OP_RST_O, POR_RESTART_O;
	wire TOD_IRQ_I, WAKE_PIN_I, STOP_RST_I, IRQ_I, STOP_EXEC_I, WAIT_EXEC_I;
	int n_mismatch = 0;
	int samples_checked = 0;
	int cyc = 0;
	assign {TOD_IRQ_I, WAKE_PIN_I, STOP_RST_I, IRQ_I, STOP_EXEC_I, WAIT_EXEC_I} = ev;
	pms_power_mode_selector dut (
		.CLOCK_I(CLOCK_I),
		.SYS_RST_I(SYS_RST_I),
		.PSEL_I(PSEL_I),
		.PENABLE_I(PENABLE_I),
		.PWRITE_I(PWRITE_I),
		.PADDR_I(PADDR_I),
		.PWDATA_I(PWDATA_I),
		.PRDATA_O(PRDATA_O),
		.PREADY_O(PREADY_O),
		.PSLVERR_O(PSLVERR_O),
		.DBG_WR_I(DBG_WR_I),
		.DBG_ENABLE_I(DBG_ENABLE_I),
		.WAIT_EXEC_I(WAIT_EXEC_I),
		.STOP_EXEC_I(STOP_EXEC_I),
		.IRQ_I(IRQ_I),
		.STOP_RST_I(STOP_RST_I),
		.WAKE_PIN_I(WAKE_PIN_I),
		.TOD_IRQ_I(TOD_IRQ_I),
		.MODE_O(MODE_O),
		.CPU_CLK_EN_O(CPU_CLK_EN_O),
		.PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
		.PERIPH_SLOW_O(PERIPH_SLOW_O),
		.DEBUG_CLK_EN_O(DEBUG_CLK_EN_O),
		.CLKGEN_LOW_POWER_O(CLKGEN_LOW_POWER_O),
		.CLKGEN_STOP_O(CLKGEN_STOP_O),
		.EXT_REF_CLK_EN_O(EXT_REF_CLK_EN_O),
		.INT_REF_CLK_EN_O(INT_REF_CLK_EN_O),
		.OSC_OUT_EN_O(OSC_OUT_EN_O),
		.REGULATOR_O(REGULATOR_O),
		.POWERDOWN_O(POWERDOWN_O),
		.IRQ_SERVICE_O(IRQ_SERVICE_O),
		.ILLEGAL_OP_RST_O(ILLEGAL_OP_RST_O),
		.POR_RESTART_O(POR_RESTART_O)
	);
	pms_cpu_model cpu (
		.clk_i(CLOCK_I),
		.ev_o(ev),
		.dbg_wr_o(DBG_WR_I),
		.dbg_en_o(DBG_ENABLE_I)
	);
	always #4 CLOCK_I = ~CLOCK_I;
	////////////////////////////////////////////////////////////////////
	task summarize;
		$display("checks %0d mismatches %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	always @(posedge CLOCK_I) begin
		cyc++;
		if (cyc == 3000) begin
			n_mismatch++;
			summarize();
		end
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge CLOCK_I);
		PSEL_I <= 1'b1;
		PWRITE_I <= w;
		PADDR_I <= a;
		PWDATA_I <= d;
		@(posedge CLOCK_I);
		PENABLE_I <= 1'b1;
		do begin
			@(posedge CLOCK_I);
		end while (PREADY_O !== 1'b1);
		rdat = PRDATA_O;
		serr = PSLVERR_O;
		PSEL_I <= 1'b0;
		PENABLE_I <= 1'b0;
	endtask
	task ev_go(input logic [5:0] m);
		cpu.pulse(m);
		#1;
	endtask
	////////////////////////////////////////////////////////////////////
	task t_lp;
		apb(1'b1, CTRL_OFS, 32'h0000_0021);
		apb(1'b1, CTRL_OFS, 32'h0000_0023);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdat, 32'h0000_0021);
		#1;
		chk(MODE_O, M_LOW_POWER_RUN);
		ev_go(6'h01);
		chk(MODE_O, M_LOW_POWER_WAIT);
		chk(PERIPH_SLOW_O, 1'b1);
		ev_go(6'h04);
		ev_go(6'h02);
		chk({MODE_O, REGULATOR_O}, {M_RSTOP, REG_STANDBY});
		ev_go(6'h04);
		chk({MODE_O, IRQ_SERVICE_O}, {M_LOW_POWER_RUN, 1'b1});
		apb(1'b1, CTRL_OFS, 32'h0000_0025);
		ev_go(6'h02);
		ev_go(6'h04);
		chk(MODE_O, M_RUN);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdat[S_LOW_POWER_RUN_STATUS], 1'b0);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdat[C_LPR], 1'b0);
	endtask
	task t_pd;
		apb(1'b1, CTRL_OFS, 32'h0000_0022);
		apb(1'b1, CTRL_OFS, 32'h0000_0023);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdat, 32'h0000_0022);
		ev_go(6'h02);
		chk({MODE_O, REGULATOR_O}, {M_PDSTOP, REG_PARTIAL});
		chk(POWERDOWN_O, 1'b1);
		ev_go(6'h10);
		chk({MODE_O, POR_RESTART_O}, {M_RUN, 1'b1});
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdat[S_PDWF], 1'b1);
		apb(1'b1, CTRL_OFS, 32'h0000_0022);
		ev_go(6'h02);
		ev_go(6'h20);
		chk({MODE_O, POR_RESTART_O}, {M_RUN, 1'b1});
		apb(1'b1, CTRL_OFS, 32'h0001_0000);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdat[S_PDWF], 1'b0);
	endtask
	task t_dbg;
		cpu.dbg(1'b1);
		#1;
		chk(DEBUG_CLK_EN_O, 1'b1);
		apb(1'b1, CTRL_OFS, 32'h0000_0022);
		ev_go(6'h02);
		chk({MODE_O, REGULATOR_O}, {M_RSTOP, REG_FULL});
		chk(DEBUG_CLK_EN_O, 1'b1);
		ev_go(6'h08);
		chk(MODE_O, M_RUN);
		apb(1'b1, STAT_OFS, 32'h0);
		apb(1'b0, STAT_OFS, 32'h0);
		chk(rdat[S_DBG], 1'b1);
		apb(1'b0, 12'h008, 32'h0);
		chk(serr, 1'b1);
		chk(rdat, 32'h0);
		cpu.dbg(1'b0);
		#1;
		chk(DEBUG_CLK_EN_O, 1'b0);
	endtask
	task t_misc;
		apb(1'b1, CTRL_OFS, 32'h0);
		apb(1'b1, CTRL_OFS, 32'h0000_0019);
		apb(1'b0, CTRL_OFS, 32'h0);
		chk(rdat, 32'h0000_0019);
		chk({MODE_O, REGULATOR_O}, {M_RUN, REG_FULL});
		apb(1'b1, CTRL_OFS, 32'h0000_03a0);
		ev_go(6'h02);
		chk({CLKGEN_STOP_O, OSC_OUT_EN_O}, 2'b11);
		chk({EXT_REF_CLK_EN_O, INT_REF_CLK_EN_O}, 2'b10);
		ev_go(6'h04);
		apb(1'b1, CTRL_OFS, 32'h0);
		ev_go(6'h01);
		chk(MODE_O, M_WAIT);
		ev_go(6'h04);
		ev_go(6'h02);
		chk({MODE_O, ILLEGAL_OP_RST_O}, {M_RUN, 1'b1});
	endtask
	initial begin
		repeat (16) @(posedge CLOCK_I);
		SYS_RST_I <= 1'b0;
		@(posedge CLOCK_I);
		chk({MODE_O, REGULATOR_O}, {M_RUN, REG_FULL});
		t_lp();
		t_pd();
		t_dbg();
		t_misc();
		summarize();
	end
endmodule
bind pms_power_mode_selector pms_props u_props (
	.CLOCK_I(CLOCK_I),
	.SYS_RST_I(SYS_RST_I),
	.DBG_WR_I(DBG_WR_I),
	.DBG_ENABLE_I(DBG_ENABLE_I),
	.STOP_EXEC_I(STOP_EXEC_I),
	.IRQ_I(IRQ_I),
	.STOP_RST_I(STOP_RST_I),
	.MODE_O(MODE_O),
	.CPU_CLK_EN_O(CPU_CLK_EN_O),
	.PERIPH_CLK_EN_O(PERIPH_CLK_EN_O),
	.DEBUG_CLK_EN_O(DEBUG_CLK_EN_O),
	.CLKGEN_LOW_POWER_O(CLKGEN_LOW_POWER_O),
	.REGULATOR_O(REGULATOR_O),
	.POWERDOWN_O(POWERDOWN_O),
	.IRQ_SERVICE_O(IRQ_SERVICE_O),
	.ILLEGAL_OP_RST_O(ILLEGAL_OP_RST_O)
);
`default_nettype wire
